// file: common/rtctb_pkg.sv
// package for the rtc timebase, calibration, pin control and write-protection core
package rtctb_pkg;

	// ==================================================================
	// register byte offsets on the avalon slave
	localparam logic [6:0] RTCTB_CTRL_OFS = 7'h08;
	localparam logic [6:0] RTCTB_STAT_OFS = 7'h0c;
	localparam logic [6:0] RTCTB_DIV_OFS = 7'h10;
	localparam logic [6:0] RTCTB_KEY_OFS = 7'h24;
	localparam logic [6:0] RTCTB_SUBSEC_OFS = 7'h28;
	localparam logic [6:0] RTCTB_SHIFT_OFS = 7'h2c;
	localparam logic [6:0] RTCTB_CALIB_OFS = 7'h3c;
	localparam logic [6:0] RTCTB_PIN_OFS = 7'h40;

	// ==================================================================
	// field positions
	localparam int RTCTB_DIV_ASYNC_LSB = 16;
	localparam int RTCTB_SHIFT_ADV_BIT = 31;
	localparam int RTCTB_CAL_W8_BIT = 13;
	localparam int RTCTB_CAL_W16_BIT = 14;
	localparam int RTCTB_CAL_INS_BIT = 15;

	// ==================================================================
	// reset values, keys and timing
	localparam logic [14:0] RTCTB_SYNC_DIV_RST = 15'h00ff;
	localparam logic [6:0] RTCTB_ASYNC_DIV_RST = 7'h7f;
	localparam logic [7:0] RTCTB_KEY_FIRST = 8'hca;
	localparam logic [7:0] RTCTB_KEY_SECOND = 8'h53;
	localparam logic [5:0] RTCTB_REF_50_EDGES = 6'h32;
	localparam logic [5:0] RTCTB_REF_60_EDGES = 6'h3c;
	localparam logic [14:0] RTCTB_REF_TOL = 15'h0007;
	localparam logic [10:0] RTCTB_INS_PERIOD_END = 11'h7ff;
	localparam int RTCTB_CAL_CNT_W = 20;
	localparam int RTCTB_CAL_OUT_512_BIT = 5;

	// ==================================================================
	// shared and oscillator pin configuration
	typedef struct packed {
		logic oscOutPinValue;
		logic oscOutPinForceEn;
		logic oscInPinValue;
		logic oscInPinForceEn;
		logic sharedPinForceEn;
		logic sharedPinValue;
		logic calOutOneHz;
		logic calibOutEn;
		logic alarmOutEn;
		logic timestampInEn;
		logic tamperInEn;
	} rtctb_pin_cfg_t;

	// one pin as two signals
	typedef struct packed {
		logic out;
		logic oe_n;
	} rtctb_pin_drv_t;

endpackage : rtctb_pkg

// file: dv/rtctb_far_side.sv
// far-side model: outside source on the shared pin and the mains reference
`timescale 1ns/1ns

// ==================================================================
// model
module rtctb_far_side (
	// shared pin as seen from outside
	input wire rtctb_pkg::rtctb_pin_drv_t sharedPinDrv,
	input wire logic extLevel,
	output logic sharedPinIn,
	// mains reference pin
	output logic mainsReferenceInput
);
	import rtctb_pkg::*;
	// device drive wins the wire, else the outside source shows through
	assign sharedPinIn = (sharedPinDrv.oe_n === 1'b0) ? sharedPinDrv.out : extLevel;
	// no mains attached, detection stays unused with free dividers
	assign mainsReferenceInput = 1'b0;
endmodule : rtctb_far_side

// file: dv/test_rtctb_core.sv
// self-checking testbench for the rtc timebase, pins and write protection
`timescale 1ns/1ns

// ==================================================================
// bench
module test_rtctb_core;
	import rtctb_pkg::*;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [6:0] avsAddress = 7'h00;
	logic avsRead = 1'b0;
	logic avsWrite = 1'b0;
	logic [31:0] avsWritedata = 32'h0;
	logic [31:0] avsReaddata;
	logic [31:0] rdata;
	logic avsWaitrequest, secondTick, tsIn, tampIn, toGpio, sharedPinIn, mainsRef;
	logic standby = 1'b0;
	logic lsEn = 1'b0;
	logic lsByp = 1'b0;
	logic alarm = 1'b0;
	logic extLevel = 1'b0;
	logic [10:0] cfg;
	logic [6:0] a;
	logic [14:0] s;
	rtctb_pin_drv_t shDrv, inDrv, outDrv;
	integer seed = 29;
	int miscompares = 0;
	int checks = 0;
	int per;

	rtctb_core dut (.ref_clk(ref_clk), .arst_n(arst_n), .avs_address(avsAddress),
		.avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata),
		.avs_byteenable(4'hf), .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest),
		.standby(standby), .lowSpeedOscEnable(lsEn), .lowSpeedOscBypass(lsByp),
		.alarmPulse(alarm), .mainsReferenceInput(mainsRef), .sharedPinIn(sharedPinIn),
		.sharedPinDrv(shDrv), .oscInPinDrv(inDrv), .oscOutPinDrv(outDrv),
		.secondTick(secondTick), .timestampInput(tsIn), .tamperInputOne(tampIn),
		.sharedPinToGpio(toGpio));
	rtctb_far_side far (.sharedPinDrv(shDrv), .extLevel(extLevel),
		.sharedPinIn(sharedPinIn), .mainsReferenceInput(mainsRef));

	// selected clock comes from outside the block
	always #4 ref_clk = ~ref_clk;

	// ==================================================================
	// tasks
	task automatic report_and_stop();
		if (miscompares == 0 && checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// held request until waitrequest is sampled low, no fixed latency assumed
	task automatic bus(input logic wr, input logic [6:0] adr, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		avsAddress <= adr;
		avsWrite <= wr;
		avsRead <= !wr;
		avsWritedata <= d;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avsWaitrequest !== 1'b0 && n < 64);
		chk(32'(n < 64), 32'h1);
		rdata = avsReaddata;
		avsRead <= 1'b0;
		avsWrite <= 1'b0;
	endtask : bus

	// skips one tick, then counts clocks to the next one
	task automatic period(output int p);
		p = 0;
		do begin
			@(posedge ref_clk);
			p++;
		end while (secondTick !== 1'b1 && p < 40000);
		p = 0;
		do begin
			@(posedge ref_clk);
			p++;
		end while (secondTick !== 1'b1 && p < 40000);
	endtask : period

	// oe_n is low while driving; out only checked where it is steady
	task automatic chkPin(input rtctb_pin_drv_t got, input logic drv, input logic known,
		input logic val);
		chk(32'(got.oe_n), 32'(!drv));
		if (drv && known) chk(32'(got.out), 32'(val));
	endtask : chkPin

	// ==================================================================
	// watchdog sized well above the longest second plus the pin loop
	initial begin
		repeat (90000) @(posedge ref_clk);
		$display("[FAIL] %0t watchdog expired", $time);
		miscompares++;
		report_and_stop();
	end

	// ==================================================================
	// main sequence
	initial begin
		repeat (6) @(posedge ref_clk);
		arst_n <= 1'b1;
		bus(0, RTCTB_STAT_OFS, 32'h0);
		chk(rdata & 32'h3, 32'h1);
		bus(1, RTCTB_DIV_OFS, 32'h0003_0004);
		bus(0, RTCTB_DIV_OFS, 32'h0);
		chk(rdata, {9'h0, RTCTB_ASYNC_DIV_RST, 1'b0, RTCTB_SYNC_DIV_RST});
		bus(1, RTCTB_KEY_OFS, {24'h0, RTCTB_KEY_FIRST});
		bus(0, RTCTB_STAT_OFS, 32'h0);
		chk(rdata & 32'h3, 32'h3);
		bus(1, RTCTB_KEY_OFS, {24'h0, RTCTB_KEY_SECOND});
		bus(0, RTCTB_STAT_OFS, 32'h0);
		chk(rdata & 32'h3, 32'h0);
		bus(0, 7'h7c, 32'h0);
		chk(rdata, 32'h0);
		// first round also waits out the reset-value second
		for (int i = 0; i < 4; i++) begin
			a = (i == 0) ? 7'h00 : 7'($unsigned($random(seed)) % 8);
			s = 15'($unsigned($random(seed)) % 16 + 1);
			bus(1, RTCTB_DIV_OFS, {9'h0, a, 1'b0, s});
			period(per);
			period(per);
			chk(per, (32'(a) + 1) * (32'(s) + 1));
		end
		// one extra count per 2048 clocks shortens a 2048-clock second by one
		bus(1, RTCTB_DIV_OFS, {9'h0, 7'h01, 1'b0, 15'h03ff});
		bus(1, RTCTB_CALIB_OFS, 32'h0000_8000);
		period(per);
		period(per);
		chk(per, 32'd2047);
		bus(1, RTCTB_CALIB_OFS, 32'h0000_21ff);
		bus(0, RTCTB_CALIB_OFS, 32'h0);
		chk(rdata & 32'h1ff, 32'h1fc);
		bus(1, RTCTB_CALIB_OFS, 32'h0000_41ff);
		bus(0, RTCTB_CALIB_OFS, 32'h0);
		chk(rdata & 32'h1ff, 32'h1fe);
		bus(1, RTCTB_CALIB_OFS, 32'h0);
		// random pin setups, masked so every priority row comes up
		for (int i = 0; i < 48; i++) begin
			cfg = 11'($random(seed));
			if (i % 2 == 1) cfg[2] = 1'b0;
			if (i % 4 == 3) cfg[3:0] = 4'h0;
			if (i % 8 == 7) cfg[6] = 1'b0;
			alarm <= 1'($random(seed));
			lsEn <= 1'($random(seed));
			lsByp <= 1'($random(seed));
			extLevel <= 1'($random(seed));
			bus(1, RTCTB_PIN_OFS, {21'h0, cfg});
			repeat (6) @(posedge ref_clk);
			if (cfg[2]) chkPin(shDrv, cfg[5] | !alarm, 1'b1, cfg[5] & alarm);
			else if (cfg[3]) chkPin(shDrv, 1'b1, 1'b0, 1'b0);
			else if (cfg[1:0] != 2'h0) begin
				chkPin(shDrv, 1'b0, 1'b0, 1'b0);
				chk(32'(tampIn), 32'(cfg[0] & extLevel));
				chk(32'(tsIn), 32'(cfg[1] & extLevel));
			end
			else chkPin(shDrv, cfg[6], 1'b1, cfg[5]);
			chk(32'(toGpio), 32'((cfg & 11'h04f) == 11'h0));
			chkPin(inDrv, !lsEn & cfg[7], 1'b1, cfg[8]);
			chkPin(outDrv, (!lsEn | lsByp) & cfg[9], 1'b1, cfg[10]);
		end
		// forced drive must survive standby even when the setup changes
		bus(1, RTCTB_PIN_OFS, 32'h0000_0060);
		repeat (4) @(posedge ref_clk);
		standby <= 1'b1;
		bus(1, RTCTB_PIN_OFS, 32'h0);
		repeat (4) @(posedge ref_clk);
		chkPin(shDrv, 1'b1, 1'b1, 1'b1);
		standby <= 1'b0;
		repeat (4) @(posedge ref_clk);
		chkPin(shDrv, 1'b0, 1'b0, 1'b0);
		// a repeated first key counts as a wrong key
		bus(1, RTCTB_KEY_OFS, {24'h0, RTCTB_KEY_FIRST});
		bus(1, RTCTB_KEY_OFS, {24'h0, RTCTB_KEY_FIRST});
		bus(0, RTCTB_STAT_OFS, 32'h0);
		chk(rdata & 32'h3, 32'h1);
		bus(1, RTCTB_PIN_OFS, 32'h0000_0060);
		repeat (4) @(posedge ref_clk);
		chkPin(shDrv, 1'b0, 1'b0, 1'b0);
		report_and_stop();
	end
endmodule : test_rtctb_core

// file: logic/rtctb_core.sv
// rtc timebase, digital calibration, pin control and write-protection core
// ==================================================================
// Notes on behaviour
// - clock output, timestamp and tamper one share the single backup pin
// - alarm on shared pin is open-drain at pin value 0, push-pull at 1
// - shared pin priority: alarm, calibration, tamper/timestamp, forced, gpio
// - forced shared pin drives its value push-pull and holds it in standby
// - with nothing enabled the shared pin is left to wake-up or gpio
// - oscillator pins forced push-pull when oscillator off; held through standby
// - clock source is chosen outside this block by the clock controller
// - two cascaded dividers: 7-bit asynchronous then 15-bit synchronous
// - asynchronous divider output clocks the synchronous one, giving the 1 Hz tick
// - subsecond down counter reloads with the synchronous divider value
// - subsecond shift field adds or removes subsecond counts, each one asynchronous divider period, for fine alignment
// - reference detection aligns the 1 Hz tick to 50 or 60 Hz mains input
// - calibration window 2^20 cycles, or 2^19 / 2^18 with window bits
// - removal count bit 0 forced low in 16 s, bits 1:0 in 8 s window
// - each window removes as many pulses as the removal count says
// - insert bit adds one pulse every 2^11 cycles
// - net change per 2^20 cycles is 512 times insert bit minus removal count, the count taken 2 or 4 times in 16 s or 8 s window
// - writes to protected registers are ignored while protection stands
// - protection set at power-on; no system reset input can clear it
// - key 0xca then 0x53 to the key register removes protection
// - any wrong key write re-enables protection at once
//
// The address map and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ns

module rtctb_core (
	// clock (selected rtc clock) and power-on reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// avalon-mm slave
	input wire logic [6:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// low-power and clock-controller status
	input wire logic standby,
	input wire logic lowSpeedOscEnable,
	input wire logic lowSpeedOscBypass,
	// alarm pulse from the alarm unit, same clock
	input wire logic alarmPulse,
	// external pins
	input wire logic mainsReferenceInput,
	input wire logic sharedPinIn,
	output rtctb_pkg::rtctb_pin_drv_t sharedPinDrv,
	output rtctb_pkg::rtctb_pin_drv_t oscInPinDrv,
	output rtctb_pkg::rtctb_pin_drv_t oscOutPinDrv,
	// events toward calendar, timestamp and tamper units
	output logic secondTick,
	output logic timestampInput,
	output logic tamperInputOne,
	output logic sharedPinToGpio
);
	import rtctb_pkg::*;

	// ==================================================================
	// state
	typedef struct packed {
		logic waitReq;
		logic [31:0] rdData;
		logic locked;
		logic keyStage;
		logic refDetectEnable;
		logic ref60;
		rtctb_pin_cfg_t pinCfg;
		logic [14:0] syncDivider;
		logic [6:0] asyncDivider;
		logic [14:0] subsecondShift;
		logic shiftAdvance;
		logic shiftPend;
		logic [8:0] pulseRemoveCount;
		logic window8sSel;
		logic window16sSel;
		logic pulseInsertBit;
		logic [6:0] asyncCnt;
		logic [14:0] subsecCnt;
		logic [RTCTB_CAL_CNT_W-1:0] calCnt;
		logic [5:0] refEdgeCnt;
		logic pinSync1;
		logic pinSync2;
		logic refSync1;
		logic refSync2;
		logic refSync3;
		logic secTick;
		rtctb_pin_drv_t shared;
		rtctb_pin_drv_t oscIn;
		rtctb_pin_drv_t oscOut;
		logic tsIn;
		logic tampIn;
		logic toGpio;
	} rtctb_state_t;

	rtctb_state_t stateReg;
	rtctb_state_t stateNext;

	logic [31:0] curImage;
	logic [31:0] wrMask;
	logic [31:0] wrImage;
	logic busReq;
	logic busAccept;
	logic wrAccept;
	logic keyWrite;
	logic protWrite;
	logic [8:0] removeEff;
	logic [RTCTB_CAL_CNT_W-1:0] winPos;
	logic removeNow;
	logic insertNow;
	logic [1:0] step;
	logic apreFire;
	logic refEdge;
	logic refSecond;

	// ==================================================================
	// register image and byte-lane merge
	always_comb begin
		curImage = 32'h0000_0000;
		unique case (avs_address)
			RTCTB_CTRL_OFS: curImage = {30'h0, stateReg.ref60, stateReg.refDetectEnable};
			RTCTB_STAT_OFS: curImage = {29'h0, stateReg.shiftPend, stateReg.keyStage,
				stateReg.locked};
			RTCTB_DIV_OFS: curImage = {9'h0, stateReg.asyncDivider, 1'b0, stateReg.syncDivider};
			RTCTB_SUBSEC_OFS: curImage = {17'h0, stateReg.subsecCnt};
			RTCTB_SHIFT_OFS: curImage = {stateReg.shiftAdvance, 16'h0, stateReg.subsecondShift};
			RTCTB_CALIB_OFS: curImage = {16'h0, stateReg.pulseInsertBit, stateReg.window16sSel,
				stateReg.window8sSel, 4'h0, stateReg.pulseRemoveCount};
			RTCTB_PIN_OFS: curImage = {21'h0, stateReg.pinCfg};
			default: curImage = 32'h0000_0000; // unmapped and key register read zero
		endcase
	end

	// byte enables widen to a bit mask
	always_comb begin
		for (int b = 0; b < 4; b++) begin
			wrMask[b*8 +: 8] = {8{avs_byteenable[b]}};
		end
		wrImage = (curImage & ~wrMask) | (avs_writedata & wrMask);
	end

	// a request is taken on the edge where waitrequest is already low
	assign busReq = avs_read || avs_write;
	assign busAccept = busReq && !stateReg.waitReq;
	assign wrAccept = busAccept && avs_write;
	assign keyWrite = wrAccept && avs_address == RTCTB_KEY_OFS && avs_byteenable[0];
	assign protWrite = wrAccept && !stateReg.locked;

	// ==================================================================
	// calibration window: removal bunched at window start, insertion every 2^11
	always_comb begin
		removeEff = stateReg.pulseRemoveCount;
		winPos = stateReg.calCnt;
		if (stateReg.window8sSel) begin
			removeEff[1:0] = 2'b00;
			winPos[19:18] = 2'b00;
		end else if (stateReg.window16sSel) begin
			removeEff[0] = 1'b0;
			winPos[19] = 1'b0;
		end
	end

	// net step per cycle: 2^20 / 2^11 = 512 insertions against the removals
	assign removeNow = winPos < {11'h0, removeEff};
	assign insertNow = stateReg.pulseInsertBit
		&& stateReg.calCnt[10:0] == RTCTB_INS_PERIOD_END;
	assign step = 2'd1 + {1'b0, insertNow} - {1'b0, removeNow};

	// asynchronous divider fires when it passes zero
	assign apreFire = (step != 2'd0) && (stateReg.asyncCnt == 7'h00
		|| (step == 2'd2 && stateReg.asyncCnt == 7'h01));

	// reference edge from the second and third sync stages only
	assign refEdge = stateReg.refSync2 && !stateReg.refSync3;
	assign refSecond = refEdge && stateReg.refDetectEnable && stateReg.refEdgeCnt
		== (stateReg.ref60 ? RTCTB_REF_60_EDGES - 6'd1 : RTCTB_REF_50_EDGES - 6'd1);

	// ==================================================================
	// next state
	always_comb begin
		stateNext = stateReg;
		stateNext.secTick = 1'b0;

		// bus handshake: one wait cycle, then one answer cycle
		stateNext.waitReq = !(busReq && stateReg.waitReq);
		if (busReq && stateReg.waitReq) begin
			stateNext.rdData = curImage;
		end

		// key sequence, always writable
		if (keyWrite) begin
			if (!stateReg.keyStage && avs_writedata[7:0] == RTCTB_KEY_FIRST) begin
				stateNext.keyStage = 1'b1;
				stateNext.locked = 1'b1;
			end else if (stateReg.keyStage && avs_writedata[7:0] == RTCTB_KEY_SECOND) begin
				stateNext.keyStage = 1'b0;
				stateNext.locked = 1'b0;
			end else begin
				stateNext.keyStage = 1'b0;
				stateNext.locked = 1'b1;
			end
		end

		// protected registers
		if (protWrite) begin
			unique case (avs_address)
				RTCTB_CTRL_OFS: begin
					stateNext.refDetectEnable = wrImage[0];
					stateNext.ref60 = wrImage[1];
				end
				RTCTB_DIV_OFS: begin
					stateNext.syncDivider = wrImage[14:0];
					stateNext.asyncDivider = wrImage[RTCTB_DIV_ASYNC_LSB +: 7];
				end
				RTCTB_SHIFT_OFS: begin
					stateNext.subsecondShift = wrImage[14:0];
					stateNext.shiftAdvance = wrImage[RTCTB_SHIFT_ADV_BIT];
					stateNext.shiftPend = 1'b1;
				end
				RTCTB_CALIB_OFS: begin
					stateNext.pulseRemoveCount = wrImage[8:0];
					// the stored count keeps the window's forced low bits, so software reads them back
					if (wrImage[RTCTB_CAL_W8_BIT]) begin
						stateNext.pulseRemoveCount[1:0] = 2'b00;
					end else if (wrImage[RTCTB_CAL_W16_BIT]) begin
						stateNext.pulseRemoveCount[0] = 1'b0;
					end
					stateNext.window8sSel = wrImage[RTCTB_CAL_W8_BIT];
					stateNext.window16sSel = wrImage[RTCTB_CAL_W16_BIT];
					stateNext.pulseInsertBit = wrImage[RTCTB_CAL_INS_BIT];
				end
				RTCTB_PIN_OFS: stateNext.pinCfg = wrImage[10:0];
				default: ;
			endcase
		end

		// calibration window counter wraps at its own length
		stateNext.calCnt = stateReg.calCnt + 20'd1;

		// asynchronous divider fed by the calibrated clock
		if (apreFire) begin
			stateNext.asyncCnt = (step == 2'd2 && stateReg.asyncCnt == 7'h00
				&& stateReg.asyncDivider != 7'h00)
				? stateReg.asyncDivider - 7'd1 : stateReg.asyncDivider;
		end else begin
			stateNext.asyncCnt = stateReg.asyncCnt - {5'h0, step};
		end

		// synchronous subsecond counter, clocked by the async divider output
		if (apreFire) begin
			if (stateReg.subsecCnt == 15'h0000) begin
				stateNext.subsecCnt = stateReg.syncDivider;
				stateNext.secTick = 1'b1;
			end else begin
				stateNext.subsecCnt = stateReg.subsecCnt - 15'd1;
			end
			// shift applies on a subsecond step so the counter never skips a tick
			if (stateReg.shiftPend && !(protWrite && avs_address == RTCTB_SHIFT_OFS)) begin
				stateNext.shiftPend = 1'b0;
				if (stateReg.shiftAdvance) begin
					stateNext.subsecCnt = (stateReg.subsecCnt > stateReg.subsecondShift)
						? stateReg.subsecCnt - stateReg.subsecondShift : 15'h0000;
				end else begin
					stateNext.subsecCnt = stateReg.subsecCnt + stateReg.subsecondShift;
				end
			end
		end

		// mains reference: count edges, realign the tick once per reference second
		stateNext.refSync1 = mainsReferenceInput;
		stateNext.refSync2 = stateReg.refSync1;
		stateNext.refSync3 = stateReg.refSync2;
		if (!stateReg.refDetectEnable) begin
			stateNext.refEdgeCnt = 6'h00;
		end else if (refSecond) begin
			stateNext.refEdgeCnt = 6'h00;
			// late internal tick: fire it now; early one: restart the second
			if (stateReg.subsecCnt <= RTCTB_REF_TOL) begin
				stateNext.subsecCnt = stateReg.syncDivider;
				stateNext.secTick = 1'b1;
			end else if (stateReg.subsecCnt >= stateReg.syncDivider - RTCTB_REF_TOL) begin
				stateNext.subsecCnt = stateReg.syncDivider;
			end
		end else if (refEdge) begin
			stateNext.refEdgeCnt = stateReg.refEdgeCnt + 6'd1;
		end

		// shared pin input synchroniser
		stateNext.pinSync1 = sharedPinIn;
		stateNext.pinSync2 = stateReg.pinSync1;

		// pins freeze in standby, keeping any forced drive and value
		if (!standby) begin
			stateNext.tsIn = 1'b0;
			stateNext.tampIn = 1'b0;
			stateNext.toGpio = 1'b0;
			stateNext.shared = '{out: 1'b0, oe_n: 1'b1};
			if (stateReg.pinCfg.alarmOutEn) begin
				if (stateReg.pinCfg.sharedPinValue) begin
					stateNext.shared = '{out: alarmPulse, oe_n: 1'b0};
				end else begin
					stateNext.shared = '{out: 1'b0, oe_n: alarmPulse};
				end
			end else if (stateReg.pinCfg.calibOutEn) begin
				stateNext.shared.oe_n = 1'b0;
				stateNext.shared.out = stateReg.pinCfg.calOutOneHz
					? stateReg.subsecCnt > (stateReg.syncDivider >> 1)
					: stateReg.calCnt[RTCTB_CAL_OUT_512_BIT];
			end else if (stateReg.pinCfg.tamperInEn || stateReg.pinCfg.timestampInEn) begin
				stateNext.tampIn = stateReg.pinCfg.tamperInEn && stateReg.pinSync2;
				stateNext.tsIn = stateReg.pinCfg.timestampInEn && stateReg.pinSync2;
			end else if (stateReg.pinCfg.sharedPinForceEn) begin
				stateNext.shared = '{out: stateReg.pinCfg.sharedPinValue, oe_n: 1'b0};
			end else begin
				stateNext.toGpio = 1'b1;
			end

			// oscillator pins: the oscillator owns them whenever it runs
			stateNext.oscIn = '{out: 1'b0, oe_n: 1'b1};
			stateNext.oscOut = '{out: 1'b0, oe_n: 1'b1};
			if (!lowSpeedOscEnable && stateReg.pinCfg.oscInPinForceEn) begin
				stateNext.oscIn = '{out: stateReg.pinCfg.oscInPinValue, oe_n: 1'b0};
			end
			// in bypass the output pin is free, so forcing still applies there
			if ((!lowSpeedOscEnable || lowSpeedOscBypass) && stateReg.pinCfg.oscOutPinForceEn) begin
				stateNext.oscOut = '{out: stateReg.pinCfg.oscOutPinValue, oe_n: 1'b0};
			end
		end
	end

	// ==================================================================
	// state register; arst_n is the power-on reset of the backup domain
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			stateReg <= '0;
			stateReg.waitReq <= 1'b1;
			stateReg.locked <= 1'b1;
			stateReg.syncDivider <= RTCTB_SYNC_DIV_RST;
			stateReg.asyncDivider <= RTCTB_ASYNC_DIV_RST;
			stateReg.asyncCnt <= RTCTB_ASYNC_DIV_RST;
			stateReg.subsecCnt <= RTCTB_SYNC_DIV_RST;
			stateReg.shared <= '{out: 1'b0, oe_n: 1'b1};
			stateReg.oscIn <= '{out: 1'b0, oe_n: 1'b1};
			stateReg.oscOut <= '{out: 1'b0, oe_n: 1'b1};
		end else begin
			stateReg <= stateNext;
		end
	end

	// ==================================================================
	// outputs, all from flip-flops; ref_clk is whatever source the clock controller picked
	assign avs_readdata = stateReg.rdData;
	assign avs_waitrequest = stateReg.waitReq;
	assign sharedPinDrv = stateReg.shared;
	assign oscInPinDrv = stateReg.oscIn;
	assign oscOutPinDrv = stateReg.oscOut;
	assign secondTick = stateReg.secTick;
	assign timestampInput = stateReg.tsIn;
	assign tamperInputOne = stateReg.tampIn;
	assign sharedPinToGpio = stateReg.toGpio;

	// ==================================================================
	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	sequence sKeyFirst;
		keyWrite && avs_writedata[7:0] == RTCTB_KEY_FIRST && !stateReg.keyStage;
	endsequence

	sequence sKeySecond;
		keyWrite && avs_writedata[7:0] == RTCTB_KEY_SECOND;
	endsequence

	sequence sKeyPair;
		sKeyFirst ##1 stateReg.keyStage ##[0:8] (keyWrite
			&& avs_writedata[7:0] == RTCTB_KEY_SECOND && stateReg.keyStage);
	endsequence

	a_key_unlock: assert property (sKeyPair |=> !stateReg.locked)
		else $error("key pair did not unlock");

	a_wrong_key: assert property (keyWrite && !(avs_writedata[7:0] == RTCTB_KEY_FIRST
		&& !stateReg.keyStage) && !(avs_writedata[7:0] == RTCTB_KEY_SECOND && stateReg.keyStage)
		|=> stateReg.locked && !stateReg.keyStage)
		else $error("wrong key left protection off");

	a_locked_ignore: assert property (wrAccept && stateReg.locked && !keyWrite
		|=> $stable(stateReg.syncDivider) && $stable(stateReg.pinCfg))
		else $error("protected register changed while locked");

	a_subsec_reload: assert property (apreFire && stateReg.subsecCnt == 15'h0000
		&& !stateReg.shiftPend && !refSecond
		|=> secondTick && stateReg.subsecCnt == $past(stateReg.syncDivider))
		else $error("subsecond counter did not reload");

	a_remove_mask: assert property (stateReg.window8sSel |-> removeEff[1:0] == 2'b00
		&& removeEff[8:2] == stateReg.pulseRemoveCount[8:2])
		else $error("removal count not masked in 8 s window");

	a_insert_step: assert property (insertNow && !removeNow |-> step == 2'd2
		##1 stateReg.calCnt[10:0] == 11'h000)
		else $error("insertion did not double the step");

	a_alarm_od: assert property (!standby && stateReg.pinCfg.alarmOutEn
		&& !stateReg.pinCfg.sharedPinValue
		|=> sharedPinDrv.out == 1'b0 && sharedPinDrv.oe_n == $past(alarmPulse))
		else $error("alarm not open-drain");

	a_force_drive: assert property (!standby && stateReg.pinCfg.sharedPinForceEn
		&& stateReg.pinCfg[3:0] == 4'h0
		|=> !sharedPinDrv.oe_n && sharedPinDrv.out == $past(stateReg.pinCfg.sharedPinValue))
		else $error("forced shared pin not driven");

	a_standby_hold: assert property (standby |=> $stable(sharedPinDrv) && $stable(oscInPinDrv)
		&& $stable(oscOutPinDrv))
		else $error("pin drive changed in standby");

	a_bus_answer: assert property (busReq && stateReg.waitReq |=> !avs_waitrequest
		##1 avs_waitrequest)
		else $error("bus answer not one cycle after request");

endmodule : rtctb_core
